// File: src/bsr_pkg.sv
// Shared constants and types for the boot strap and reset control block.
package bsr_pkg;
    localparam int          CLK_PERIOD_NS       = 20;
    localparam int          STRAP_SETTLE_CYCLES = 3;
    localparam logic [31:0] RESET_VECTOR_ADDR   = 32'h0000_0000;
    localparam int          SCAN_LENGTH         = 8;
    localparam int          SYNC_WIDTH          = 8;
    localparam int          SYN_EPROM           = 0;
    localparam int          SYN_LINK            = 1;
    localparam int          SYN_BSEL            = 2;
    localparam int          SYN_TRI_N           = 3;
    localparam int          SYN_TCK             = 4;
    localparam int          SYN_TMS             = 5;
    localparam int          SYN_TDI             = 6;
    localparam int          SYN_TRST_N          = 7;

    typedef enum logic [2:0] {
        BSR_BOOT_EPROM    = 3'h0,
        BSR_BOOT_HOST     = 3'h1,
        BSR_BOOT_LINK     = 3'h2,
        BSR_BOOT_NONE     = 3'h3,
        BSR_BOOT_RESERVED = 3'h4
    } bsr_mode_t;

    typedef enum logic [3:0] {
        BSR_TAP_RESET      = 4'h0,
        BSR_TAP_IDLE       = 4'h1,
        BSR_TAP_SEL_DR     = 4'h2,
        BSR_TAP_CAPTURE_DR = 4'h3,
        BSR_TAP_SHIFT_DR   = 4'h4,
        BSR_TAP_EXIT1_DR   = 4'h5,
        BSR_TAP_PAUSE_DR   = 4'h6,
        BSR_TAP_EXIT2_DR   = 4'h7,
        BSR_TAP_UPDATE_DR  = 4'h8,
        BSR_TAP_SEL_IR     = 4'h9,
        BSR_TAP_CAPTURE_IR = 4'hA,
        BSR_TAP_SHIFT_IR   = 4'hB,
        BSR_TAP_EXIT1_IR   = 4'hC,
        BSR_TAP_PAUSE_IR   = 4'hD,
        BSR_TAP_EXIT2_IR   = 4'hE,
        BSR_TAP_UPDATE_IR  = 4'hF
    } bsr_tap_state_t;
endpackage

// File: src/bsr_tap_if.sv
// Signals between the strap controller and its test access port engine.
`timescale 1ns/1ns
interface bsr_tap_if #(
    parameter int SCAN_LEN = bsr_pkg::SCAN_LENGTH
);
    logic                    tck_rise;
    logic                    tck_fall;
    logic                    tms;
    logic                    tdi;
    logic                    trst_n;
    logic [SCAN_LEN-1:0]     capture_data;
    logic                    tdo;
    logic                    tdo_oe;
    bsr_pkg::bsr_tap_state_t state;

    modport ctrl (
        output tck_rise,
        output tck_fall,
        output tms,
        output tdi,
        output trst_n,
        output capture_data,
        input  tdo,
        input  tdo_oe,
        input  state
    );
    modport tap (
        input  tck_rise,
        input  tck_fall,
        input  tms,
        input  tdi,
        input  trst_n,
        input  capture_data,
        output tdo,
        output tdo_oe,
        output state
    );
endinterface

// File: src/bsr_tap.sv
// Test state machine and boundary scan shift path, stepped by test clock edges.
`timescale 1ns/1ns
module bsr_tap #(
    parameter int SCAN_LEN = bsr_pkg::SCAN_LENGTH
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    bsr_tap_if.tap    tif
);
    // The shift path slices from bit 1 upward, so a one-bit chain cannot be built.
    if (SCAN_LEN < 2) begin : g_scan_len_bad
        $error("bsr_tap: SCAN_LEN must be at least 2");
    end

    typedef struct packed {
        bsr_pkg::bsr_tap_state_t state;
        logic [SCAN_LEN-1:0]     shift;
        logic                    tdo;
        logic                    tdo_oe;
    } bsr_tap_reg_t;

    bsr_tap_reg_t tap_ff;
    bsr_tap_reg_t nxt_tap;

    function automatic bsr_pkg::bsr_tap_state_t bsr_tap_next(
        input bsr_pkg::bsr_tap_state_t s,
        input logic                    m
    );
        case (s)
            bsr_pkg::BSR_TAP_RESET:
                return m ? bsr_pkg::BSR_TAP_RESET : bsr_pkg::BSR_TAP_IDLE;
            bsr_pkg::BSR_TAP_IDLE:
                return m ? bsr_pkg::BSR_TAP_SEL_DR : bsr_pkg::BSR_TAP_IDLE;
            bsr_pkg::BSR_TAP_SEL_DR:
                return m ? bsr_pkg::BSR_TAP_SEL_IR : bsr_pkg::BSR_TAP_CAPTURE_DR;
            bsr_pkg::BSR_TAP_CAPTURE_DR:
                return m ? bsr_pkg::BSR_TAP_EXIT1_DR : bsr_pkg::BSR_TAP_SHIFT_DR;
            bsr_pkg::BSR_TAP_SHIFT_DR:
                return m ? bsr_pkg::BSR_TAP_EXIT1_DR : bsr_pkg::BSR_TAP_SHIFT_DR;
            bsr_pkg::BSR_TAP_EXIT1_DR:
                return m ? bsr_pkg::BSR_TAP_UPDATE_DR : bsr_pkg::BSR_TAP_PAUSE_DR;
            bsr_pkg::BSR_TAP_PAUSE_DR:
                return m ? bsr_pkg::BSR_TAP_EXIT2_DR : bsr_pkg::BSR_TAP_PAUSE_DR;
            bsr_pkg::BSR_TAP_EXIT2_DR:
                return m ? bsr_pkg::BSR_TAP_UPDATE_DR : bsr_pkg::BSR_TAP_SHIFT_DR;
            bsr_pkg::BSR_TAP_UPDATE_DR:
                return m ? bsr_pkg::BSR_TAP_SEL_DR : bsr_pkg::BSR_TAP_IDLE;
            bsr_pkg::BSR_TAP_SEL_IR:
                return m ? bsr_pkg::BSR_TAP_RESET : bsr_pkg::BSR_TAP_CAPTURE_IR;
            bsr_pkg::BSR_TAP_CAPTURE_IR:
                return m ? bsr_pkg::BSR_TAP_EXIT1_IR : bsr_pkg::BSR_TAP_SHIFT_IR;
            bsr_pkg::BSR_TAP_SHIFT_IR:
                return m ? bsr_pkg::BSR_TAP_EXIT1_IR : bsr_pkg::BSR_TAP_SHIFT_IR;
            bsr_pkg::BSR_TAP_EXIT1_IR:
                return m ? bsr_pkg::BSR_TAP_UPDATE_IR : bsr_pkg::BSR_TAP_PAUSE_IR;
            bsr_pkg::BSR_TAP_PAUSE_IR:
                return m ? bsr_pkg::BSR_TAP_EXIT2_IR : bsr_pkg::BSR_TAP_PAUSE_IR;
            bsr_pkg::BSR_TAP_EXIT2_IR:
                return m ? bsr_pkg::BSR_TAP_UPDATE_IR : bsr_pkg::BSR_TAP_SHIFT_IR;
            bsr_pkg::BSR_TAP_UPDATE_IR:
                return m ? bsr_pkg::BSR_TAP_SEL_DR : bsr_pkg::BSR_TAP_IDLE;
            default:
                return bsr_pkg::BSR_TAP_RESET;
        endcase
    endfunction

    always_comb begin
        nxt_tap = tap_ff;
        if (!tif.trst_n) begin
            nxt_tap.state  = bsr_pkg::BSR_TAP_RESET;
            nxt_tap.tdo_oe = 1'b0;
        end else if (tif.tck_rise) begin
            nxt_tap.state = bsr_tap_next(tap_ff.state, tif.tms);
            if (tap_ff.state == bsr_pkg::BSR_TAP_CAPTURE_DR) begin
                nxt_tap.shift = tif.capture_data;
            end else if (tap_ff.state == bsr_pkg::BSR_TAP_SHIFT_DR) begin
                nxt_tap.shift = {tif.tdi, tap_ff.shift[SCAN_LEN-1:1]};
            end
        end else if (tif.tck_fall) begin
            // The output changes on the falling test clock so the far end samples it settled.
            nxt_tap.tdo    = tap_ff.shift[0];
            nxt_tap.tdo_oe = (tap_ff.state == bsr_pkg::BSR_TAP_SHIFT_DR);
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tap_ff <= '{state: bsr_pkg::BSR_TAP_RESET, shift: '0, tdo: 1'b0, tdo_oe: 1'b0};
        end else begin
            tap_ff <= nxt_tap;
        end
    end

    assign tif.tdo    = tap_ff.tdo;
    assign tif.tdo_oe = tap_ff.tdo_oe;
    assign tif.state  = tap_ff.state;
endmodule

// File: src/bsr_top.sv
// Boot strap decoding, boot select pin control, reset start-up and test port hookup.
`timescale 1ns/1ns
module bsr_top #(
    parameter logic [31:0] RESET_VECTOR = bsr_pkg::RESET_VECTOR_ADDR,
    parameter int          SCAN_LEN     = bsr_pkg::SCAN_LENGTH
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        eprom_boot_strap,
    input  wire logic        link_boot_strap,
    input  wire logic        boot_memory_select_in,
    output logic             boot_memory_select_out,
    output logic             boot_memory_select_oe,
    input  wire logic        bus_three_state_request_n,
    input  wire logic        bus_master,
    input  wire logic        eprom_read_req,
    input  wire logic        test_clock,
    input  wire logic        test_mode_select,
    input  wire logic        test_data_in,
    input  wire logic        test_reset_n,
    output logic             test_data_out,
    output logic             test_data_out_oe,
    output logic             emulation_status_out,
    output logic             emulation_status_out_oe,
    output logic             reserved_output,
    output logic [2:0]       boot_mode,
    output logic             strap_fault,
    output logic             boot_locked,
    output logic             fetch_start,
    output logic [31:0]      fetch_addr,
    output logic             instr_cycle_en
);
    if (SCAN_LEN < 2) begin : g_scan_len_bad
        $error("bsr_top: SCAN_LEN must be at least 2 to hold the captured straps");
    end

    localparam int SW = bsr_pkg::SYNC_WIDTH;

    typedef struct packed {
        logic [SW-1:0]     sync1;
        logic [SW-1:0]     sync2;
        logic              tck_prev;
        logic [2:0]        settle;
        logic              locked;
        bsr_pkg::bsr_mode_t mode;
        logic              fault;
        logic              fetch_start;
        logic              instr_cycle;
        logic              cs_n;
        logic              cs_oe;
        logic              emu_oe;
    } bsr_state_t;

    bsr_state_t st_ff;
    bsr_state_t nxt_st;
    bsr_tap_if #(.SCAN_LEN(SCAN_LEN)) tif ();

    function automatic bsr_pkg::bsr_mode_t bsr_decode(
        input logic eprom,
        input logic link,
        input logic bsel
    );
        if (eprom && !link) begin
            return bsr_pkg::BSR_BOOT_EPROM;
        end else if (eprom || (link && !bsel)) begin
            return bsr_pkg::BSR_BOOT_RESERVED;
        end else if (!bsel) begin
            return bsr_pkg::BSR_BOOT_NONE;
        end else if (link) begin
            return bsr_pkg::BSR_BOOT_LINK;
        end else begin
            return bsr_pkg::BSR_BOOT_HOST;
        end
    endfunction

    always_comb begin
        logic drive_ok;
        drive_ok = 1'b0;
        nxt_st = st_ff;
        nxt_st.sync1 = {test_reset_n, test_data_in, test_mode_select, test_clock,
                        bus_three_state_request_n, boot_memory_select_in,
                        link_boot_strap, eprom_boot_strap};
        nxt_st.sync2 = st_ff.sync1;
        nxt_st.tck_prev = st_ff.sync2[bsr_pkg::SYN_TCK];
        nxt_st.fetch_start = 1'b0;
        nxt_st.instr_cycle = 1'b1;
        // Straps are resampled until the synchronisers have settled, then frozen.
        if (!st_ff.locked) begin
            nxt_st.mode  = bsr_decode(st_ff.sync2[bsr_pkg::SYN_EPROM],
                                      st_ff.sync2[bsr_pkg::SYN_LINK],
                                      st_ff.sync2[bsr_pkg::SYN_BSEL]);
            nxt_st.fault = (nxt_st.mode == bsr_pkg::BSR_BOOT_RESERVED);
            if (st_ff.settle == 3'(bsr_pkg::STRAP_SETTLE_CYCLES)) begin
                nxt_st.locked      = 1'b1;
                nxt_st.fetch_start = 1'b1;
            end else begin
                nxt_st.settle = st_ff.settle + 3'h1;
            end
        end
        // Floating while a three-state request or slave status holds avoids bus contention.
        drive_ok = st_ff.locked && (st_ff.mode == bsr_pkg::BSR_BOOT_EPROM) && bus_master
                   && st_ff.sync2[bsr_pkg::SYN_TRI_N];
        nxt_st.cs_oe = drive_ok;
        nxt_st.cs_n  = !(drive_ok && eprom_read_req);
        // Status is flagged open-drain while the test port has left its reset state.
        nxt_st.emu_oe = (tif.state != bsr_pkg::BSR_TAP_RESET);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st_ff <= '{sync1: '0, sync2: '0, tck_prev: 1'b0, settle: 3'h0, locked: 1'b0,
                       mode: bsr_pkg::BSR_BOOT_HOST, fault: 1'b0, fetch_start: 1'b0,
                       instr_cycle: 1'b0, cs_n: 1'b1, cs_oe: 1'b0, emu_oe: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tif.tck_rise     = st_ff.sync2[bsr_pkg::SYN_TCK] && !st_ff.tck_prev;
    assign tif.tck_fall     = !st_ff.sync2[bsr_pkg::SYN_TCK] && st_ff.tck_prev;
    assign tif.tms          = st_ff.sync2[bsr_pkg::SYN_TMS];
    assign tif.tdi          = st_ff.sync2[bsr_pkg::SYN_TDI];
    assign tif.trst_n       = st_ff.sync2[bsr_pkg::SYN_TRST_N];
    assign tif.capture_data = {{(SCAN_LEN-2){1'b0}}, st_ff.sync2[bsr_pkg::SYN_LINK],
                               st_ff.sync2[bsr_pkg::SYN_EPROM]};

    bsr_tap #(.SCAN_LEN(SCAN_LEN)) u_tap (
        .sys_clk (sys_clk),
        .rst     (rst),
        .tif     (tif.tap)
    );

    assign boot_memory_select_out  = st_ff.cs_n;
    assign boot_memory_select_oe   = st_ff.cs_oe;
    assign test_data_out           = tif.tdo;
    assign test_data_out_oe        = tif.tdo_oe;
    assign emulation_status_out    = 1'b0;
    assign emulation_status_out_oe = st_ff.emu_oe;
    assign reserved_output         = 1'b0;
    assign boot_mode               = st_ff.mode;
    assign strap_fault             = st_ff.fault;
    assign boot_locked             = st_ff.locked;
    assign fetch_start             = st_ff.fetch_start;
    assign fetch_addr              = RESET_VECTOR;
    assign instr_cycle_en          = st_ff.instr_cycle;
endmodule

// File: tb/bsr_top_asserts.sv
// Port checks for the boot strap and reset control block.
`timescale 1ns/1ns
module bsr_top_asserts #(
    parameter logic [31:0] RESET_VECTOR = bsr_pkg::RESET_VECTOR_ADDR
) (
    input logic        sys_clk,
    input logic        rst,
    input logic        bus_master,
    input logic        eprom_read_req,
    input logic        boot_memory_select_out,
    input logic        boot_memory_select_oe,
    input logic [2:0]  boot_mode,
    input logic        strap_fault,
    input logic        boot_locked,
    input logic        fetch_start,
    input logic [31:0] fetch_addr,
    input logic        instr_cycle_en
);
    // Saturates, so the lock edge is matched once per reset.
    logic [2:0] since_rst_ff;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            since_rst_ff <= 3'h0;
        end else if (since_rst_ff != 3'h7) begin
            since_rst_ff <= since_rst_ff + 3'h1;
        end
    end
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    chk_oe_gate: assert property (boot_memory_select_oe |-> $past(bus_master)
        && boot_locked && boot_mode == bsr_pkg::BSR_BOOT_EPROM)
        else $error("select driven outside eprom");
    chk_oe_release: assert property (boot_memory_select_oe && !bus_master |=>
        !boot_memory_select_oe) else $error("select kept after mastership lost");
    chk_cs_level: assert property (boot_memory_select_oe |->
        boot_memory_select_out == !$past(eprom_read_req)) else $error("chip select wrong");
    chk_fault_code: assert property (strap_fault ==
        (boot_mode == bsr_pkg::BSR_BOOT_RESERVED)) else $error("fault flag disagrees with mode");
    chk_lock_hold: assert property (boot_locked |=> boot_locked && $stable(boot_mode))
        else $error("locked mode changed");
    chk_lock_time: assert property (boot_locked == (since_rst_ff >= 3'h4))
        else $error("lock at wrong edge");
    chk_fetch_once: assert property (fetch_start == (since_rst_ff == 3'h4))
        else $error("fetch start misplaced");
    chk_fetch_vector: assert property (fetch_start |-> fetch_addr == RESET_VECTOR)
        else $error("fetch address wrong");
    chk_cycle_each: assert property (instr_cycle_en == (since_rst_ff != 3'h0))
        else $error("instruction cycle missing");
    cov_eprom: cover property (fetch_start && boot_mode == bsr_pkg::BSR_BOOT_EPROM);
    cov_drive: cover property (boot_memory_select_oe && !boot_memory_select_out);
    cov_fault: cover property (strap_fault && boot_locked);
endmodule
bind bsr_top bsr_top_asserts #(.RESET_VECTOR(RESET_VECTOR)) chk_u (
    .sys_clk, .rst, .bus_master, .eprom_read_req, .boot_memory_select_out,
    .boot_memory_select_oe, .boot_mode, .strap_fault, .boot_locked, .fetch_start,
    .fetch_addr, .instr_cycle_en);

// File: tb/bsr_tap_ctl.sv
// Test controller model that clocks the test port from outside.
`timescale 1ns/1ns
module bsr_tap_ctl (
    input  logic sys_clk,
    input  logic test_data_out,
    output logic test_clock,
    output logic test_mode_select,
    output logic test_data_in,
    output logic test_reset_n
);
    // Phases must span several system clocks or the synchroniser misses them.
    localparam int HALF = 8;
    initial begin
        test_clock       = 1'b0;
        test_mode_select = 1'b1;
        test_data_in     = 1'b1;
        test_reset_n     = 1'b0;
    end
    task automatic trst_pulse();
        test_reset_n = 1'b0;
        repeat (HALF) @(negedge sys_clk);
        test_reset_n = 1'b1;
        repeat (HALF) @(negedge sys_clk);
    endtask
    task automatic step(input logic m, input logic d, output logic o);
        test_mode_select = m;
        test_data_in     = d;
        repeat (HALF) @(negedge sys_clk);
        o          = test_data_out;
        test_clock = 1'b1;
        repeat (HALF) @(negedge sys_clk);
        test_clock = 1'b0;
    endtask
endmodule

// File: tb/tb.sv
// Self-checking bench for the boot strap and reset control block.
`timescale 1ns/1ns
module tb;
    logic        sys_clk, rst, eprom_boot_strap, link_boot_strap, boot_memory_select_in;
    logic        boot_memory_select_out, boot_memory_select_oe, bus_three_state_request_n;
    logic        bus_master, eprom_read_req, test_clock, test_mode_select, test_data_in;
    logic        test_reset_n, test_data_out, test_data_out_oe, emulation_status_out;
    logic        emulation_status_out_oe, reserved_output, strap_fault, boot_locked;
    logic        fetch_start, instr_cycle_en;
    logic [2:0]  boot_mode;
    logic [31:0] fetch_addr;
    int          fails = 0;
    int          n_tests = 0;
    int          cycles = 0;
    bsr_top dut_u (.*);
    bsr_tap_ctl ctl_u (.sys_clk, .test_data_out, .test_clock, .test_mode_select,
        .test_data_in, .test_reset_n);
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic boot(input logic [2:0] s);
        int k = 0;
        @(negedge sys_clk);
        rst = 1'b1;
        {eprom_boot_strap, link_boot_strap, boot_memory_select_in} = s;
        @(negedge sys_clk);
        check("reset select", {boot_memory_select_oe, boot_memory_select_out}, 2'b01);
        @(negedge sys_clk);
        rst = 1'b0;
        while (fetch_start !== 1'b1 && k < 10) begin
            @(negedge sys_clk);
            k++;
        end
        check("lock delay", k, 4);
        check("fetch address", fetch_addr, bsr_pkg::RESET_VECTOR_ADDR);
        check("cycle enable", instr_cycle_en, 1'b1);
        @(negedge sys_clk);
        check("start pulse", {fetch_start, boot_locked}, 2'b01);
    endtask
    task automatic t_decode();
        logic [2:0] m;
        for (int i = 0; i < 8; i++) begin
            boot(3'(i));
            m = i[2] ? (i[1] ? 3'h4 : 3'h0) : (i[1] ? (i[0] ? 3'h2 : 3'h4) : (i[0] ? 3'h1 : 3'h3));
            check("boot mode", boot_mode, m);
            check("strap fault", strap_fault, m == 3'h4);
            {eprom_boot_strap, link_boot_strap, boot_memory_select_in} = ~3'(i);
            repeat (4) @(negedge sys_clk);
            check("held mode", boot_mode, m);
        end
    endtask
    task automatic t_select_pin();
        boot(3'h5);
        bus_master = 1'b1;
        eprom_read_req = 1'b1;
        @(negedge sys_clk);
        check("select drive", {boot_memory_select_oe, boot_memory_select_out}, 2'b10);
        eprom_read_req = 1'b0;
        @(negedge sys_clk);
        check("select idle", boot_memory_select_out, 1'b1);
        bus_master = 1'b0;
        @(negedge sys_clk);
        check("slave float", boot_memory_select_oe, 1'b0);
        bus_master = 1'b1;
        bus_three_state_request_n = 1'b0;
        repeat (3) @(negedge sys_clk);
        check("request float", boot_memory_select_oe, 1'b0);
        bus_three_state_request_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        check("request end", boot_memory_select_oe, 1'b1);
        eprom_read_req = 1'b1;
        boot(3'h1);
        repeat (2) @(negedge sys_clk);
        check("host input", boot_memory_select_oe, 1'b0);
        bus_master = 1'b0;
        eprom_read_req = 1'b0;
    endtask
    task automatic t_test_port();
        logic        o;
        logic [15:0] exp = {8'hA5, 8'h01};
        boot(3'h5);
        ctl_u.trst_pulse();
        ctl_u.step(1'b0, 1'b1, o);
        ctl_u.step(1'b1, 1'b1, o);
        ctl_u.step(1'b0, 1'b1, o);
        ctl_u.step(1'b0, 1'b1, o);
        // The last falling test clock reaches the port three system clocks after the pin.
        repeat (3) @(negedge sys_clk);
        check("emulation active", emulation_status_out_oe, 1'b1);
        check("scan enable", test_data_out_oe, 1'b1);
        for (int k = 0; k < 16; k++) begin
            ctl_u.step(1'b0, exp[(k % 8) + 8], o);
            check("scan bit", o, exp[k]);
        end
        ctl_u.step(1'b1, 1'b1, o);
        ctl_u.step(1'b1, 1'b1, o);
        check("scan release", test_data_out_oe, 1'b0);
        ctl_u.trst_pulse();
        check("test reset", emulation_status_out_oe, 1'b0);
        check("spare outputs", {reserved_output, emulation_status_out}, 2'b00);
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    // A hang in any handshake ends the run here as a failure.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles > 20000) begin
            fails++;
            finish_test();
        end
    end
    initial begin
        rst = 1'b1;
        {eprom_boot_strap, link_boot_strap, boot_memory_select_in} = 3'h5;
        {bus_three_state_request_n, bus_master, eprom_read_req} = 3'h4;
        repeat (2) @(negedge sys_clk);
        rst = 1'b0;
        t_decode();
        t_select_pin();
        t_test_port();
        finish_test();
    end
endmodule
